// File: lsl_cfg.svh
`ifndef LSL_CFG_SVH
`define LSL_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define LSL_A_DATA7    5'h07
`define LSL_A_CTRL     5'h08
`define LSL_A_STAT     5'h09
`define LSL_A_ERR      5'h0A
`define LSL_A_LEN      5'h0B
`define LSL_A_BIT_TIME_DIVIDER    5'h0C
`define LSL_A_BTIME    5'h0D
`define LSL_A_ID       5'h0E
`define LSL_A_BUSTIME  5'h0F
`define LSL_A_IOCFG    5'h10
`define LSL_A_THR_RISE 5'h11
`define LSL_A_THR_FALL 5'h12

// ****************************************
// Field positions
// ****************************************
`define LSL_C_DIR      0
`define LSL_C_ACK      1
`define LSL_C_STOP     2
`define LSL_C_INTERRUPT_RESET_BIT   3
`define LSL_C_ERROR_RESET_BIT   4
`define LSL_C_SLEEP    5
`define LSL_C_WAKEREQ  6
`define LSL_S_DREQ     0
`define LSL_S_CMPL     1
`define LSL_S_ERR      2
`define LSL_S_IDLE     3
`define LSL_S_WAKE     4
`define LSL_S_SLEEP    5
`define LSL_E_BIT      0
`define LSL_E_CHK      1
`define LSL_E_TOUT     2
`define LSL_F_ENH      7
`define LSL_F_IDLE     0
`define LSL_F_WUP      4
`define LSL_IO_TXSRC   0
`define LSL_IO_EXT     1
`define LSL_IO_SHORT   2

// ****************************************
// Reset values and length codes
// ****************************************
`define LSL_RST_THR    8'h30
`define LSL_RST_BIT_TIME_DIVIDER  9'h138
`define LSL_RST_PRESCL 2'h3
`define LSL_RST_BTMUL  4'h1
`define LSL_LEN_AUTO   4'hF
`define LSL_LEN_MAX    4'h8
`define LSL_LEN_ID_0X  4'h2
`define LSL_LEN_ID_10  4'h4
`define LSL_LEN_ID_11  4'h8

// ****************************************
// Timing
// ****************************************
`define LSL_CLK_NS        10
`define LSL_MS_NS         1000000
`define LSL_WAKE_PULSE_NS 250000
`define LSL_TXD_TMO_NS    10000000
`define LSL_BRK_BITS      11
`define LSL_MS_PER_S      1000
`define LSL_WUP_MS_00     180
`define LSL_WUP_MS_01     200
`define LSL_WUP_MS_10     220
`define LSL_WUP_MS_11     240
`define LSL_IDLE_S_00     4
`define LSL_IDLE_S_01     6
`define LSL_IDLE_S_10     8
`define LSL_IDLE_S_11     10

`endif

// File: lsl_pkg.sv
package lsl_pkg;
	typedef logic [7:0] lsl_byte_t;
	typedef enum {
		S_IDLE,
		S_BRK,
		S_SYNW,
		S_SYNC,
		S_START,
		S_BIT,
		S_DONE,
		S_ACK,
		S_STOP,
		S_WAKE,
		S_WWAIT
	} lsl_state_e;
endpackage : lsl_pkg

// File: lsl_glitch_filter.sv
`include "lsl_cfg.svh"
module lsl_glitch_filter
	import lsl_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      rst,
	input  wire logic      din,
	input  wire lsl_byte_t thr_rise,
	input  wire lsl_byte_t thr_fall,
	output logic           dout
);
	lsl_byte_t cnt;
	lsl_byte_t thr;

	assign thr = din ? thr_rise : thr_fall;

	// Level changes only after the new level held for thr cycles
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt  <= 8'h00;
			dout <= 1'b1;
		end else if (din == dout) begin
			cnt <= 8'h00;
		end else if (cnt + 8'h01 >= thr) begin
			cnt  <= 8'h00;
			dout <= din;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule : lsl_glitch_filter

// File: lsl_tx_monitor.sv
`include "lsl_cfg.svh"
module lsl_tx_monitor
	import lsl_pkg::*;
#(
	parameter int TIMEOUT = 1000
)(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic txd,
	output logic      tx_en
);
	localparam int CW = $clog2(TIMEOUT + 1);

	logic [CW-1:0] cnt;
	logic          txd_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt   <= '0;
			txd_q <= 1'b1;
			tx_en <= 1'b1;
		end else begin
			txd_q <= txd;
			if (txd)
				cnt <= '0;
			else if (cnt != CW'(TIMEOUT))
				cnt <= cnt + CW'(1);
			if (txd && !txd_q)
				tx_en <= 1'b1;
			else if (!txd && cnt == CW'(TIMEOUT - 1))
				tx_en <= 1'b0;
		end
	end
endmodule : lsl_tx_monitor

// File: lsl_link_core.sv
`include "lsl_cfg.svh"
// How it works
// - Two receive filters sharing separately programmable rise and fall thresholds
// - Stuck-low transmit input disables transmitter
// - Transmit source: controller or general pin
// - Shorted bus switches pull-up off
// - External mode bypasses internal transceiver
// - Length code 1111b decodes from identifier
// - Identifier bits give 2, 4, 8 bytes
// - Classic checksum over data bytes
// - Enhanced checksum includes protected identifier
// - Wake repeat time 180 to 240 ms
// - Inactivity time 4 to 10 s
// - Break threshold from prescaler, divider, multiplier
// - Sync field measures the master bit time
// - Interrupt on identifier, wake, error, completion
// - Stop halts processing until next break
// - Bit mismatch flags error and aborts
module lsl_link_core
	import lsl_pkg::*;
#(
	parameter int MS_CYCLES   = `LSL_MS_NS / `LSL_CLK_NS,
	parameter int WAKE_CYCLES = `LSL_WAKE_PULSE_NS / `LSL_CLK_NS,
	parameter int TXD_CYCLES  = `LSL_TXD_TMO_NS / `LSL_CLK_NS
)(
	input  wire logic       CLK,
	input  wire logic       RST,
	input  wire logic [4:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	input  wire logic       PHY_RXD,
	input  wire logic       EXT_RXD,
	input  wire logic       GPIO_TXD,
	output logic            PHY_TXD,
	output logic            PHY_TX_EN,
	output logic            EXT_TXD,
	output logic            PULLUP_EN,
	output logic            IRQ
);
	localparam int MSW = $clog2(MS_CYCLES + 1);
	localparam int WKA = $clog2(WAKE_CYCLES + 1);
	localparam int WKW = (WKA > 8) ? WKA : 8;

	// ****************************************
	// Declarations
	// ****************************************
	logic [2:0]     sync1;
	logic [2:0]     sync2;
	lsl_byte_t      thr_rise;
	lsl_byte_t      thr_fall;
	lsl_byte_t      len_cfg;
	lsl_byte_t      bustime;
	lsl_byte_t      id_pid;
	lsl_byte_t      shift;
	lsl_byte_t      sum;
	lsl_byte_t      data_buf [8];
	logic [8:0]     bt_div;
	logic [1:0]     prescl;
	logic [3:0]     bit_time_multiplier;
	logic           tx_dir;
	logic           tx_src;
	logic           ext_mode;
	logic           short_en;
	logic           sleep;
	logic           data_req;
	logic           complete;
	logic           idle_tout;
	logic           wakeup;
	logic [2:0]     err;
	logic           rx_phy;
	logic           rx_ext;
	logic           rx;
	logic           rx_q;
	logic           fall;
	logic           tx_sel;
	logic           mon_en;
	logic           ctrl_tx;
	logic [2:0]     pre_cnt;
	logic           tick;
	logic [15:0]    nominal;
	logic [19:0]    brk_lim;
	logic [19:0]    low_cnt;
	logic           brk_event;
	logic [MSW-1:0] ms_cnt;
	logic           ms_tick;
	logic [13:0]    inact_ms;
	logic [7:0]     wake_ms;
	logic [13:0]    idle_ms;
	logic [13:0]    gnd_ms;
	logic           idle_hit;
	lsl_state_e     state;
	logic [15:0]    ph;
	logic [15:0]    bit_len;
	logic [19:0]    meas;
	logic [3:0]     bitn;
	logic [3:0]     idx;
	logic [3:0]     dlen;
	logic [WKW-1:0] wcnt;
	logic           in_id;
	logic           txing;
	logic           ev_id;
	logic           ev_cmpl;
	logic           ev_bit;
	logic           ev_chk;
	logic           ev_tout;
	logic           ev_rwake;
	logic           wr_ctrl;
	logic           ack_req;
	logic           stop_req;
	logic           rst_int;
	logic           rst_err;
	lsl_byte_t      cur_byte;
	lsl_byte_t      nsum;
	lsl_byte_t      init_sum;

	function automatic lsl_byte_t csum_add(lsl_byte_t s, lsl_byte_t b);
		logic [8:0] t;
		t = {1'b0, s} + {1'b0, b};
		return t[7:0] + {7'h00, t[8]};
	endfunction : csum_add

	// ****************************************
	// Pin synchronisers and receive path
	// ****************************************
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sync1 <= 3'h7;
			sync2 <= 3'h7;
		end else begin
			sync1 <= {GPIO_TXD, EXT_RXD, PHY_RXD};
			sync2 <= sync1;
		end
	end

	lsl_glitch_filter u_flt_phy (
		.clk      (CLK),
		.rst      (RST),
		.din      (sync2[0]),
		.thr_rise (thr_rise),
		.thr_fall (thr_fall),
		.dout     (rx_phy)
	);
	lsl_glitch_filter u_flt_ext (
		.clk      (CLK),
		.rst      (RST),
		.din      (sync2[1]),
		.thr_rise (thr_rise),
		.thr_fall (thr_fall),
		.dout     (rx_ext)
	);

	assign rx   = ext_mode ? rx_ext : rx_phy;
	assign fall = rx_q & ~rx;

	// ****************************************
	// Transmit path
	// ****************************************
	assign tx_sel = tx_src ? sync2[2] : ctrl_tx;

	lsl_tx_monitor #(
		.TIMEOUT (TXD_CYCLES)
	) u_txmon (
		.clk   (CLK),
		.rst   (RST),
		.txd   (tx_sel),
		.tx_en (mon_en)
	);

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rx_q      <= 1'b1;
			PHY_TXD   <= 1'b1;
			PHY_TX_EN <= 1'b1;
			EXT_TXD   <= 1'b1;
		end else begin
			rx_q      <= rx;
			PHY_TXD   <= ext_mode ? 1'b1 : tx_sel;
			PHY_TX_EN <= mon_en & ~ext_mode;
			EXT_TXD   <= ext_mode ? tx_sel : 1'b1;
		end
	end

	// ****************************************
	// Bit timing and break detection
	// ****************************************
	assign tick    = pre_cnt == 3'((4'h1 << prescl) - 4'h1);
	assign nominal = 16'(bt_div) * (16'(bit_time_multiplier) + 16'h0001);
	assign brk_lim = 20'(nominal) * 20'(`LSL_BRK_BITS);
	assign brk_event = tick && !rx && low_cnt == brk_lim - 20'h0_0001;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pre_cnt <= 3'h0;
			low_cnt <= 20'h0_0000;
		end else begin
			pre_cnt <= tick ? 3'h0 : pre_cnt + 3'h1;
			if (rx)
				low_cnt <= 20'h0_0000;
			else if (tick && low_cnt < brk_lim)
				low_cnt <= low_cnt + 20'h0_0001;
		end
	end

	// ****************************************
	// Millisecond timers
	// ****************************************
	assign ms_tick = ms_cnt == MSW'(MS_CYCLES - 1);

	always_comb begin
		unique case (bustime[`LSL_F_WUP +: 2])
			2'h0: wake_ms = 8'(`LSL_WUP_MS_00);
			2'h1: wake_ms = 8'(`LSL_WUP_MS_01);
			2'h2: wake_ms = 8'(`LSL_WUP_MS_10);
			2'h3: wake_ms = 8'(`LSL_WUP_MS_11);
		endcase
		unique case (bustime[`LSL_F_IDLE +: 2])
			2'h0: inact_ms = 14'(`LSL_IDLE_S_00 * `LSL_MS_PER_S);
			2'h1: inact_ms = 14'(`LSL_IDLE_S_01 * `LSL_MS_PER_S);
			2'h2: inact_ms = 14'(`LSL_IDLE_S_10 * `LSL_MS_PER_S);
			2'h3: inact_ms = 14'(`LSL_IDLE_S_11 * `LSL_MS_PER_S);
		endcase
	end

	assign idle_hit = ms_tick && !sleep && rx == rx_q &&
		idle_ms == inact_ms - 14'h0001;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ms_cnt    <= '0;
			idle_ms   <= 14'h0000;
			gnd_ms    <= 14'h0000;
			PULLUP_EN <= 1'b1;
		end else begin
			ms_cnt <= ms_tick ? '0 : ms_cnt + MSW'(1);
			if (rx != rx_q || sleep)
				idle_ms <= 14'h0000;
			else if (ms_tick && idle_ms != inact_ms)
				idle_ms <= idle_ms + 14'h0001;
			if (rx)
				gnd_ms <= 14'h0000;
			else if (ms_tick && gnd_ms != inact_ms)
				gnd_ms <= gnd_ms + 14'h0001;
			if (rx)
				PULLUP_EN <= 1'b1;
			else if (short_en && gnd_ms == inact_ms)
				PULLUP_EN <= 1'b0;
		end
	end

	// ****************************************
	// Host register port
	// ****************************************
	assign wr_ctrl  = WR && ADDR == `LSL_A_CTRL;
	assign ack_req  = wr_ctrl && WDATA[`LSL_C_ACK];
	assign stop_req = wr_ctrl && WDATA[`LSL_C_STOP];
	assign rst_int  = wr_ctrl && WDATA[`LSL_C_INTERRUPT_RESET_BIT];
	assign rst_err  = wr_ctrl && WDATA[`LSL_C_ERROR_RESET_BIT];

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			thr_rise <= `LSL_RST_THR;
			thr_fall <= `LSL_RST_THR;
			len_cfg  <= 8'h00;
			bustime  <= 8'h00;
			bt_div   <= `LSL_RST_BIT_TIME_DIVIDER;
			prescl   <= `LSL_RST_PRESCL;
			bit_time_multiplier   <= `LSL_RST_BTMUL;
			tx_dir   <= 1'b0;
			tx_src   <= 1'b0;
			ext_mode <= 1'b0;
			short_en <= 1'b0;
		end else if (WR) begin
			unique case (ADDR)
				`LSL_A_CTRL:     tx_dir <= WDATA[`LSL_C_DIR];
				`LSL_A_LEN:      len_cfg <= WDATA;
				`LSL_A_BIT_TIME_DIVIDER:    bt_div[7:0] <= WDATA;
				`LSL_A_BTIME: begin
					bt_div[8] <= WDATA[0];
					prescl    <= WDATA[2:1];
					bit_time_multiplier    <= WDATA[7:4];
				end
				`LSL_A_BUSTIME:  bustime <= WDATA;
				`LSL_A_IOCFG: begin
					tx_src   <= WDATA[`LSL_IO_TXSRC];
					ext_mode <= WDATA[`LSL_IO_EXT];
					short_en <= WDATA[`LSL_IO_SHORT];
				end
				`LSL_A_THR_RISE: thr_rise <= WDATA;
				`LSL_A_THR_FALL: thr_fall <= WDATA;
				default: ;
			endcase
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			RDATA <= 8'h00;
		end else begin
			RDATA <= 8'h00;
			if (RD) begin
				if (ADDR <= `LSL_A_DATA7)
					RDATA <= data_buf[ADDR[2:0]];
				unique case (ADDR)
					`LSL_A_CTRL: begin
						RDATA[`LSL_C_DIR]   <= tx_dir;
						RDATA[`LSL_C_SLEEP] <= sleep;
					end
					`LSL_A_STAT: begin
						RDATA[`LSL_S_DREQ]  <= data_req;
						RDATA[`LSL_S_CMPL]  <= complete;
						RDATA[`LSL_S_ERR]   <= |err;
						RDATA[`LSL_S_IDLE]  <= idle_tout;
						RDATA[`LSL_S_WAKE]  <= wakeup;
						RDATA[`LSL_S_SLEEP] <= sleep;
					end
					`LSL_A_ERR:     RDATA <= {5'h00, err};
					`LSL_A_LEN:     RDATA <= len_cfg;
					`LSL_A_BIT_TIME_DIVIDER:   RDATA <= bt_div[7:0];
					`LSL_A_BTIME:   RDATA <= {bit_time_multiplier, 1'b0, prescl, bt_div[8]};
					`LSL_A_ID:      RDATA <= id_pid;
					`LSL_A_BUSTIME: RDATA <= bustime;
					`LSL_A_IOCFG:   RDATA <= {5'h00, short_en, ext_mode, tx_src};
					`LSL_A_THR_RISE: RDATA <= thr_rise;
					`LSL_A_THR_FALL: RDATA <= thr_fall;
					default: ;
				endcase
			end
		end
	end

	// ****************************************
	// Length and checksum
	// ****************************************
	always_comb begin
		if (len_cfg[3:0] == `LSL_LEN_AUTO) begin
			if (!id_pid[5])
				dlen = `LSL_LEN_ID_0X;
			else
				dlen = id_pid[4] ? `LSL_LEN_ID_11 : `LSL_LEN_ID_10;
		end else if (len_cfg[3:0] > `LSL_LEN_MAX) begin
			dlen = `LSL_LEN_MAX;
		end else begin
			dlen = len_cfg[3:0];
		end
	end

	// Enhanced start value is the protected identifier
	assign init_sum = len_cfg[`LSL_F_ENH] ? id_pid : 8'h00;
	assign cur_byte = txing ? data_buf[idx[2:0]] : shift;
	assign nsum     = csum_add(sum, cur_byte);

	// ****************************************
	// Frame engine
	// ****************************************
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state   <= S_IDLE;
			ph      <= 16'h0000;
			bit_len <= 16'h0001;
			meas    <= 20'h0_0000;
			bitn    <= 4'h0;
			idx     <= 4'h0;
			shift   <= 8'h00;
			sum     <= 8'h00;
			id_pid  <= 8'h00;
			wcnt    <= '0;
			in_id   <= 1'b0;
			txing   <= 1'b0;
			ctrl_tx <= 1'b1;
			ev_id   <= 1'b0;
			ev_cmpl <= 1'b0;
			ev_bit  <= 1'b0;
			ev_chk  <= 1'b0;
			ev_tout <= 1'b0;
			for (int i = 0; i < 8; i++)
				data_buf[i] <= 8'h00;
		end else begin
			ev_id   <= 1'b0;
			ev_cmpl <= 1'b0;
			ev_bit  <= 1'b0;
			ev_chk  <= 1'b0;
			ev_tout <= 1'b0;
			if (WR && ADDR <= `LSL_A_DATA7)
				data_buf[ADDR[2:0]] <= WDATA;
			if (brk_event && state != S_WAKE) begin
				state   <= S_BRK;
				ctrl_tx <= 1'b1;
				txing   <= 1'b0;
			end else begin
				unique case (state)
					S_IDLE: if (wr_ctrl && WDATA[`LSL_C_WAKEREQ]) begin
						state   <= S_WAKE;
						wcnt    <= '0;
						ctrl_tx <= 1'b0;
					end
					S_BRK: if (rx) state <= S_SYNW;
					S_SYNW: if (fall) begin
						state <= S_SYNC;
						meas  <= 20'h0_0000;
						bitn  <= 4'h0;
					end
					S_SYNC: begin
						if (tick)
							meas <= meas + 20'h0_0001;
						if (fall) begin
							bitn <= bitn + 4'h1;
							if (bitn == 4'h3) begin
								bit_len <= meas[18:3];
								in_id   <= 1'b1;
								state   <= S_START;
							end
						end
					end
					S_START: if (fall) begin
						state <= S_BIT;
						ph    <= 16'h0000;
						bitn  <= 4'h0;
					end
					S_BIT: if (tick) begin
						ph <= (ph == bit_len - 16'h0001) ? 16'h0000 : ph + 16'h0001;
						if (ph == {1'b0, bit_len[15:1]}) begin
							if (txing && rx != ctrl_tx) begin
								ev_bit  <= 1'b1;
								ctrl_tx <= 1'b1;
								state   <= S_IDLE;
							end else if (!txing && bitn == 4'h9) begin
								state <= S_DONE;
							end else if (!txing && bitn != 4'h0) begin
								shift <= {rx, shift[7:1]};
							end
						end else if (ph == bit_len - 16'h0001) begin
							bitn <= bitn + 4'h1;
							if (txing) begin
								ctrl_tx <= shift[0];
								shift   <= {1'b1, shift[7:1]};
								if (bitn == 4'h9)
									state <= S_DONE;
							end
						end
					end
					S_DONE: begin
						if (in_id) begin
							id_pid <= shift;
							in_id  <= 1'b0;
							ev_id  <= 1'b1;
							state  <= S_ACK;
						end else if (idx == dlen) begin
							if (!txing && shift != ~sum)
								ev_chk <= 1'b1;
							else
								ev_cmpl <= 1'b1;
							state <= S_IDLE;
						end else begin
							if (!txing)
								data_buf[idx[2:0]] <= shift;
							sum <= nsum;
							idx <= idx + 4'h1;
							if (txing) begin
								shift <= (idx + 4'h1 == dlen) ? ~nsum :
									data_buf[3'(idx + 4'h1)];
								ctrl_tx <= 1'b0;
								ph      <= 16'h0000;
								bitn    <= 4'h0;
								state   <= S_BIT;
							end else begin
								state <= S_START;
							end
						end
					end
					S_ACK: if (stop_req) begin
						state <= S_STOP;
					end else if (ack_req) begin
						sum   <= init_sum;
						idx   <= 4'h0;
						txing <= WDATA[`LSL_C_DIR];
						if (WDATA[`LSL_C_DIR]) begin
							shift   <= (dlen == 4'h0) ? ~init_sum : data_buf[0];
							ctrl_tx <= 1'b0;
							ph      <= 16'h0000;
							bitn    <= 4'h0;
							state   <= S_BIT;
						end else begin
							state <= S_START;
						end
					end
					S_STOP: ;
					S_WAKE: begin
						wcnt <= wcnt + WKW'(1);
						if (wcnt == WKW'(WAKE_CYCLES - 1)) begin
							ctrl_tx <= 1'b1;
							wcnt    <= '0;
							state   <= S_WWAIT;
						end
					end
					S_WWAIT: if (fall) begin
						state <= S_IDLE;
					end else if (ms_tick) begin
						wcnt <= wcnt + WKW'(1);
						if (wcnt == WKW'(wake_ms - 8'h01)) begin
							ev_tout <= 1'b1;
							state   <= S_IDLE;
						end
					end
				endcase
			end
		end
	end

	// ****************************************
	// Status, errors and interrupt request
	// ****************************************
	assign ev_rwake = sleep && fall;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			data_req  <= 1'b0;
			complete  <= 1'b0;
			idle_tout <= 1'b0;
			wakeup    <= 1'b0;
			sleep     <= 1'b0;
			err       <= 3'h0;
			IRQ       <= 1'b0;
		end else begin
			if (ev_id)
				data_req <= 1'b1;
			else if (ack_req || stop_req)
				data_req <= 1'b0;
			if (ev_cmpl)
				complete <= 1'b1;
			else if (rst_int)
				complete <= 1'b0;
			if (idle_hit)
				idle_tout <= 1'b1;
			else if (rst_int)
				idle_tout <= 1'b0;
			if (ev_tout || ev_rwake)
				wakeup <= 1'b1;
			else if (rst_int)
				wakeup <= 1'b0;
			if (idle_hit)
				sleep <= 1'b1;
			else if (wr_ctrl)
				sleep <= WDATA[`LSL_C_SLEEP];
			err <= (err & ~{3{rst_err}}) | {ev_tout, ev_chk, ev_bit};
			if (ev_id || ev_cmpl || ev_bit || ev_chk || ev_tout ||
				ev_rwake || idle_hit)
				IRQ <= 1'b1;
			else if (rst_int)
				IRQ <= 1'b0;
		end
	end
endmodule : lsl_link_core

// File: lsl_link_core_properties.sv
`include "lsl_cfg.svh"
module lsl_link_core_props
	import lsl_pkg::*;
#(
	parameter int MS_CYCLES   = 1,
	parameter int WAKE_CYCLES = 1,
	parameter int TXD_CYCLES  = 1
)(
	input wire logic       CLK,
	input wire logic       RST,
	input wire logic [4:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WR,
	input wire logic       RD,
	input wire logic [7:0] RDATA,
	input wire logic       PHY_RXD,
	input wire logic       EXT_RXD,
	input wire logic       GPIO_TXD,
	input wire logic       PHY_TXD,
	input wire logic       PHY_TX_EN,
	input wire logic       EXT_TXD,
	input wire logic       PULLUP_EN,
	input wire logic       IRQ
);
	logic [15:0] low_n;
	logic [9:0]  high_n;
	logic        clr_w;
	assign clr_w = WR && ADDR == `LSL_A_CTRL && WDATA[`LSL_C_INTERRUPT_RESET_BIT];
	// Cycles of transmit low, saturating
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			low_n <= '0;
		end else begin
			low_n <= PHY_TXD ? '0 : low_n + {15'h0, ~&low_n};
		end
	end
	// Cycles of bus high, saturating
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			high_n <= '0;
		end else begin
			high_n <= !(PHY_RXD && EXT_RXD) ? '0 : high_n + {9'h0, ~&high_n};
		end
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	sequence s_release;
		$fell(RST);
	endsequence
	sequence s_stuck;
		int'(low_n) > TXD_CYCLES + 8;
	endsequence
	property p_release;
		s_release |-> PHY_TXD && PHY_TX_EN && EXT_TXD && PULLUP_EN
			&& !IRQ && RDATA == 8'h00;
	endproperty
	a_release: assert property (p_release)
		else $error("outputs not idle after reset");
	property p_rd_quiet;
		!RD |=> RDATA == 8'h00;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet)
		else $error("read data without read");
	property p_ext;
		!EXT_TXD |-> PHY_TXD && !PHY_TX_EN;
	endproperty
	a_ext: assert property (p_ext)
		else $error("internal driver active in external mode");
	property p_stuck;
		s_stuck |-> !PHY_TX_EN;
	endproperty
	a_stuck: assert property (p_stuck)
		else $error("transmitter on while stuck low");
	property p_txen_back;
		$rose(PHY_TX_EN) |-> PHY_TXD;
	endproperty
	a_txen_back: assert property (p_txen_back)
		else $error("transmitter back while low");
	property p_pullup;
		int'(high_n) > 300 |-> PULLUP_EN;
	endproperty
	a_pullup: assert property (p_pullup)
		else $error("pull-up off with bus high");
	property p_irq_hold;
		IRQ && !clr_w |=> IRQ;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("interrupt dropped by itself");
	property p_irq_fall;
		$fell(IRQ) |-> $past(clr_w);
	endproperty
	a_irq_fall: assert property (p_irq_fall)
		else $error("interrupt fell without clear");
endmodule : lsl_link_core_props

// File: lsl_mm.sv
module lsl_mm
	import lsl_pkg::*;
#(
	parameter int BT = 50
)(
	input  wire logic clk,
	input  wire logic bus,
	output logic      tx
);
	initial tx = 1'b1;
	// Bits LSB first, one bit time each
	task automatic bits(input logic [9:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			tx <= v[i];
			repeat (BT) @(posedge clk);
		end
	endtask : bits
	task automatic sbyte(input lsl_byte_t d);
		bits({1'b1, d, 1'b0}, 10);
	endtask : sbyte
	// Break, delimiter, sync, identifier
	task automatic hdr(input lsl_byte_t id);
		bits(10'h000, 10);
		bits(10'h008, 4);
		sbyte(8'h55);
		sbyte(id);
	endtask : hdr
	task automatic rbyte(output lsl_byte_t d);
		int k;
		k = 0;
		while (bus !== 1'b0 && k < 2000) begin
			@(posedge clk);
			k++;
		end
		repeat (BT / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BT) @(posedge clk);
			d[i] = bus;
		end
		repeat (BT) @(posedge clk);
	endtask : rbyte
endmodule : lsl_mm

// File: lsl_link_core_bench.sv
module lsl_link_core_bench
	import lsl_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MS_C = 1, WAKE_C = 50, TXD_C = 600, BT_C = 50;
	logic       clk, rst, wr_s, rd_s, gpio;
	logic [4:0] addr;
	lsl_byte_t  wdata, rdata, b;
	logic       phy_txd, phy_en, ext_txd, pull, irq;
	wire        mtx, bus;
	int         fail_count, n_compared, w, e;
	lsl_byte_t  dat[8] = '{8'hF0, 8'h21, 8'h5A, 8'h0F, 8'h99, 8'h3C,
		8'hA5, 8'h77};
	lsl_byte_t  ids[4] = '{8'h05, 8'h12, 8'hA3, 8'hF0};
	int         nb[4] = '{2, 2, 4, 8};
	assign bus = mtx & (phy_txd | ~phy_en) & ext_txd;
	lsl_link_core #(.MS_CYCLES(MS_C), .WAKE_CYCLES(WAKE_C),
		.TXD_CYCLES(TXD_C)) uut (
		.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
		.RD(rd_s), .RDATA(rdata), .PHY_RXD(bus), .EXT_RXD(bus),
		.GPIO_TXD(gpio), .PHY_TXD(phy_txd), .PHY_TX_EN(phy_en),
		.EXT_TXD(ext_txd), .PULLUP_EN(pull), .IRQ(irq)
	);
	lsl_mm #(.BT(BT_C)) m (.clk(clk), .bus(bus), .tx(mtx));
	task automatic wr(input logic [4:0] a, input lsl_byte_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr
	task automatic chk8(input lsl_byte_t got, input lsl_byte_t exp);
		n_compared++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			fail_count++;
		end
	endtask : chk8
	task automatic rc(input logic [4:0] a, input lsl_byte_t exp);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 chk8(rdata, exp);
	endtask : rc
	task automatic wirq(output int n);
		n = 0;
		while (irq !== 1'b1 && n < 30000) begin
			@(posedge clk);
			n++;
		end
		chk8({7'h0, irq}, 8'h01);
	endtask : wirq
	function automatic lsl_byte_t cks(input lsl_byte_t sd, input int n);
		logic [8:0] s;
		s = {1'b0, sd};
		for (int i = 0; i < n; i++) begin
			s = s + {1'b0, dat[i]};
			if (s[8]) s = s - 9'd255;
		end
		return ~s[7:0];
	endfunction : cks
	task automatic rxf(input lsl_byte_t id, input lsl_byte_t len,
		input int n, input lsl_byte_t cs);
		m.hdr(id);
		wirq(w);
		rc(5'h0E, id);
		wr(5'h0B, len);
		wr(5'h08, 8'h0A);
		for (int i = 0; i < n; i++) m.sbyte(dat[i]);
		m.sbyte(cs);
		wirq(w);
	endtask : rxf
	task automatic results;
		$display("fail_count %0d n_compared %0d", fail_count, n_compared);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (90000) @(posedge clk);
		fail_count++;
		results();
	end
	initial begin
		rst = 1'b1;
		wr_s = 1'b0;
		rd_s = 1'b0;
		gpio = 1'b1;
		addr = 5'h00;
		wdata = 8'h00;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (70) @(posedge clk);
		rc(5'h11, 8'h30);
		rc(5'h12, 8'h30);
		rc(5'h0C, 8'h38);
		rc(5'h0D, 8'h17);
		rc(5'h1F, 8'h00);
		wr(5'h11, 8'h04);
		wr(5'h12, 8'h04);
		wr(5'h0C, 8'h19);
		wr(5'h0D, 8'h10);
		wr(5'h0F, 8'h33);
		rc(5'h0F, 8'h33);
		for (int i = 0; i < 8; i++) wr(i[4:0], dat[i]);
		rc(5'h07, dat[7]);
		for (int k = 0; k < 4; k++) begin
			rxf(ids[k], 8'h8F, nb[k], cks(ids[k], nb[k]));
			rc(5'h09, 8'h02);
			wr(5'h08, 8'h18);
		end
		wr(5'h02, 8'h00);
		rxf(8'h12, 8'h03, 3, cks(8'h00, 3));
		rc(5'h09, 8'h02);
		rc(5'h02, dat[2]);
		rxf(8'h12, 8'h83, 3, cks(8'h00, 3));
		rc(5'h0A, 8'h02);
		wr(5'h08, 8'h18);
		m.hdr(8'h12);
		wirq(w);
		wr(5'h08, 8'h0C);
		for (int i = 0; i < 3; i++) m.sbyte(dat[i]);
		chk8({7'h0, irq}, 8'h00);
		rc(5'h09, 8'h00);
		wr(5'h10, 8'h02);
		m.hdr(8'h30);
		wirq(w);
		wr(5'h0B, 8'h04);
		wr(5'h08, 8'h0B);
		for (int i = 0; i < 4; i++) begin
			m.rbyte(b);
			chk8(b, dat[i]);
		end
		m.rbyte(b);
		chk8(b, cks(8'h00, 4));
		wirq(w);
		rc(5'h09, 8'h02);
		wr(5'h08, 8'h18);
		m.hdr(8'h30);
		wirq(w);
		wr(5'h08, 8'h0B);
		m.bits(10'h100, 9);
		wirq(w);
		rc(5'h0A, 8'h01);
		wr(5'h08, 8'h18);
		wr(5'h10, 8'h00);
		for (int k = 0; k < 4; k++) begin
			wr(5'h0F, {2'h0, k[1:0], 4'h0});
			wr(5'h08, 8'h40);
			wirq(w);
			e = 50 + 180 + 20 * k;
			chk8({7'h0, w >= e - 4 && w <= e + 12}, 8'h01);
			rc(5'h0A, 8'h04);
			wr(5'h08, 8'h18);
		end
		for (int k = 0; k < 4; k++) begin
			wr(5'h0F, {6'h0, k[1:0]});
			wr(5'h08, 8'h18);
			m.bits(10'h002, 2);
			wirq(w);
			e = (4 + 2 * k) * 1000;
			chk8({7'h0, w >= e - 60 && w <= e + 20}, 8'h01);
			rc(5'h09, 8'h28);
		end
		wr(5'h0F, 8'h00);
		wr(5'h10, 8'h04);
		wr(5'h08, 8'h18);
		m.bits(10'h000, 1);
		wirq(w);
		repeat (10) @(posedge clk);
		chk8({7'h0, pull}, 8'h00);
		m.bits(10'h3FF, 1);
		chk8({7'h0, pull}, 8'h01);
		wr(5'h10, 8'h01);
		@(posedge clk);
		gpio <= 1'b0;
		repeat (20) @(posedge clk);
		chk8({7'h0, phy_txd}, 8'h00);
		repeat (650) @(posedge clk);
		chk8({7'h0, phy_en}, 8'h00);
		gpio <= 1'b1;
		repeat (10) @(posedge clk);
		chk8({7'h0, phy_en}, 8'h01);
		results();
	end
endmodule : lsl_link_core_bench
bind lsl_link_core lsl_link_core_props #(.MS_CYCLES(MS_CYCLES),
	.WAKE_CYCLES(WAKE_CYCLES), .TXD_CYCLES(TXD_CYCLES)) chk (
	.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
	.RDATA(RDATA), .PHY_RXD(PHY_RXD), .EXT_RXD(EXT_RXD),
	.GPIO_TXD(GPIO_TXD), .PHY_TXD(PHY_TXD), .PHY_TX_EN(PHY_TX_EN),
	.EXT_TXD(EXT_TXD), .PULLUP_EN(PULLUP_EN), .IRQ(IRQ)
);
